/* rtl/rdlf_defines.svh */
`ifndef RDLF_DEFINES_SVH
`define RDLF_DEFINES_SVH
`define RDLF_OFS_FLAGS 8'hb4
`define RDLF_OFS_PORT 8'hb3
`define RDLF_OFS_THRESH 8'hb2
`define RDLF_OFS_CTRL 8'hb1
`define RDLF_OFS_ISTAT 8'hc0
`define RDLF_OFS_IMASK 8'hc1
`define RDLF_BIT_FULL 0
`define RDLF_BIT_NEAR 1
`define RDLF_BIT_EMPTY 2
`define RDLF_BIT_STAT 3
`define RDLF_BIT_MSG 4
`define RDLF_EOM_GOOD 2'h0
`define RDLF_EOM_ERR 2'h1
`define RDLF_EOM_ABORT 2'h2
`define RDLF_EOM_PART 2'h3
`define RDLF_IRQ_MSG 0
`define RDLF_IRQ_NEAR 1
`define RDLF_IRQ_FULL 2
`define RDLF_SIX_BIT_PACKING_LAST 3'd5
`define RDLF_EIGHT_BIT_PACKING_LAST 3'd7
`define RDLF_CNT_MAX 6'h3f
`endif

/* rtl/rdlf_pkg.sv */
package rdlf_pkg;
   typedef enum logic [1:0] {RDLF_HDLC, RDLF_EIGHT_BIT_PACKING, RDLF_SIX_BIT_PACKING} rdlf_mode_e;
endpackage : rdlf_pkg

/* rtl/rdlf_fifo_readout.sv */
// What this block does
// RULE1: Received channel bits are packed into each data byte from the LSB toward the MSB.
// RULE2: In HDLC and eight-bit packing modes every data byte carries eight received bits.
// RULE3: In six-bit packing mode only bits 5:0 of each data byte are filled.
// RULE4: With a non-empty FIFO, next_read_is_status tells whether the next read is status or data.
// RULE5: next_read_is_status is 1 only when non-empty and the head byte is a status word.
// RULE6: next_read_is_status is 0 when the FIFO is empty and no message is in progress.
// RULE7: The processor checks next_read_is_status before each FIFO read or on a message interrupt.
// RULE8: A status byte holds a 2-bit end-of-message code over a 6-bit byte count.
// RULE9: After a status byte with count N, the next N reads return data only.
// RULE10: Near-full asserts when the number of empty locations equals the threshold, of 64; the code never asserts it while the threshold is zero.
// RULE11: The empty flag is high with no bytes stored and drops once any byte is written.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`include "rdlf_defines.svh"
module rdlf_fifo_readout
   import rdlf_pkg::*;
#(
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk_sys_i, // System clock, 10 MHz.
   input wire logic rst_n_i, // Synchronous reset, active low.
   input wire logic bit_valid_i, // One received channel bit is offered.
   input wire logic bit_i, // Received channel bit.
   input wire logic msg_start_i, // A message opens (pulse).
   input wire logic msg_end_i, // A message closes (pulse).
   input wire logic [1:0] msg_eom_i, // End-of-message code with msg_end_i.
   input wire logic [7:0] addr_i, // Register address.
   input wire logic [7:0] wdata_i, // Register write data.
   input wire logic wr_i, // Write strobe.
   input wire logic rd_i, // Read strobe.
   output logic [7:0] rdata_o, // Read data, cycle after rd_i.
   output logic irq_o // Level interrupt.
);
   localparam logic [AW:0] DEPTH_W = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [DEPTH-1:0] is_stat;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic [7:0] shreg;
      logic [2:0] nbits;
      logic [5:0] mcnt;
      logic [AW-1:0] stat_slot;
      logic active;
      logic [1:0] mode;
      logic [5:0] thresh;
      logic [2:0] istat;
      logic [2:0] imask;
      logic near_q;
      logic [7:0] rdata;
   } rdlf_state_s;

   rdlf_state_s r, next_r;

   function automatic logic [7:0] status_byte(input logic [1:0] end_of_message_code, input logic [5:0] n);
      status_byte = {end_of_message_code, n}; // [RULE8]
   endfunction : status_byte

   // Pointer wrap is implicit in the pointer width, so DEPTH must equal 2**AW.
   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = p + 1'b1;
   endfunction : ptr_inc

   // HDLC and eight-bit packing close a byte after bit 7, six-bit packing after bit 5.
   function automatic logic [2:0] last_bit(input logic [1:0] m);
      last_bit = (rdlf_mode_e'(m) == RDLF_SIX_BIT_PACKING) ? `RDLF_SIX_BIT_PACKING_LAST
         : `RDLF_EIGHT_BIT_PACKING_LAST; // [RULE2] [RULE3]
   endfunction : last_bit

   function automatic logic [7:0] flags_byte(input logic act, input logic stat,
         input logic mt, input logic nf, input logic fl);
      flags_byte = {3'b000, act, stat, mt, nf, fl};
   endfunction : flags_byte

   logic empty; // No byte stored.
   logic full; // All locations used.
   logic near; // Empty locations equal a nonzero threshold.
   logic nxt_stat; // Head byte is a status word.
   logic in1; // One byte enters the FIFO this cycle.
   logic in2; // Copy of in1 for the occupancy update.
   logic rdf; // One byte leaves the FIFO this cycle.
   logic [2:0] width_m1; // Index of the last bit of a data byte.
   logic [7:0] packed_b; // Assembly byte with the incoming bit placed.

   assign empty = (r.cnt == '0); // [RULE11]
   assign full = (r.cnt == DEPTH_W);
   assign near = (r.thresh != 6'h0) && ((DEPTH_W - r.cnt) == {1'b0, r.thresh}); // [RULE10]
   assign nxt_stat = !empty && r.is_stat[r.rp]; // [RULE4] [RULE5] [RULE6]

   always_comb begin
      next_r = r;
      rdf = 1'b0;
      in1 = 1'b0;
      in2 = 1'b0;
      width_m1 = last_bit(r.mode); // [RULE2] [RULE3]
      packed_b = r.shreg;

      // Read data is held for exactly one cycle and is zero otherwise, so a stale
      // value can never be mistaken for a fresh FIFO byte.
      next_r.rdata = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            `RDLF_OFS_FLAGS: next_r.rdata = flags_byte(r.active, nxt_stat, empty, near, full);
            `RDLF_OFS_PORT: begin
               next_r.rdata = empty ? 8'h00 : r.mem[r.rp];
               rdf = !empty;
            end
            `RDLF_OFS_THRESH: next_r.rdata = {2'b00, r.thresh};
            `RDLF_OFS_CTRL: next_r.rdata = {6'h00, r.mode};
            `RDLF_OFS_ISTAT: next_r.rdata = {5'h00, r.istat};
            `RDLF_OFS_IMASK: next_r.rdata = {5'h00, r.imask};
            default: next_r.rdata = 8'h00;
         endcase
      end

      // Status bits are cleared first, so an event in the same cycle wins below.
      if (wr_i) begin
         unique case (addr_i)
            `RDLF_OFS_THRESH: next_r.thresh = wdata_i[5:0];
            `RDLF_OFS_CTRL: next_r.mode = wdata_i[1:0];
            `RDLF_OFS_ISTAT: next_r.istat = r.istat & ~wdata_i[2:0];
            `RDLF_OFS_IMASK: next_r.imask = wdata_i[2:0];
            default: ;
         endcase
      end

      // A read of an empty FIFO returns zero and leaves the pointers alone.
      if (rdf) begin
         next_r.rp = ptr_inc(r.rp);
      end
      // A status slot is reserved at message start and filled at its end, so the
      // count in it matches the data bytes that follow it, except that error and abort codes store a count of zero.
      if (msg_start_i && !r.active && !full) begin
         next_r.active = 1'b1;
         next_r.stat_slot = r.wp;
         next_r.mem[r.wp] = status_byte(`RDLF_EOM_GOOD, 6'h0);
         next_r.is_stat[r.wp] = 1'b1;
         next_r.wp = ptr_inc(r.wp);
         next_r.mcnt = 6'h0;
         next_r.nbits = 3'd0;
         in1 = 1'b1;
      end else if (r.active && bit_valid_i) begin
         packed_b[r.nbits] = bit_i; // [RULE1]
         next_r.shreg = packed_b;
         next_r.nbits = r.nbits + 3'd1;
         if (r.nbits == width_m1) begin
            next_r.nbits = 3'd0;
            next_r.shreg = 8'h00;
            // A full FIFO or a count field at its limit closes the message as
            // partial; the byte just assembled is dropped rather than corrupting a slot.
            if (full || r.mcnt == `RDLF_CNT_MAX) begin
               next_r.mem[r.stat_slot] = status_byte(`RDLF_EOM_PART, r.mcnt); // [RULE9]
               next_r.active = 1'b0;
               next_r.istat[`RDLF_IRQ_FULL] = full;
               next_r.istat[`RDLF_IRQ_MSG] = 1'b1;
            end else begin
               next_r.mem[r.wp] = packed_b;
               next_r.is_stat[r.wp] = 1'b0;
               next_r.wp = ptr_inc(r.wp);
               next_r.mcnt = r.mcnt + 6'h1;
               in1 = 1'b1;
            end
         end
      end else if (r.active && msg_end_i) begin
         next_r.active = 1'b0;
         next_r.mem[r.stat_slot] = (msg_eom_i == `RDLF_EOM_ERR || msg_eom_i == `RDLF_EOM_ABORT)
            ? status_byte(msg_eom_i, 6'h0) : status_byte(msg_eom_i, r.mcnt); // [RULE9]
         next_r.istat[`RDLF_IRQ_MSG] = 1'b1;
      end

      // At most one byte enters and one leaves per cycle, so the occupancy
      // moves by one or stays.
      in2 = in1;
      unique case ({in2, rdf})
         2'b10: next_r.cnt = r.cnt + 1'b1;
         2'b01: next_r.cnt = r.cnt - 1'b1;
         default: ;
      endcase

      // The near interrupt fires on the rising edge of the level, so software
      // sees one event per crossing rather than a stream while it drains.
      next_r.near_q = near;
      if (near && !r.near_q) begin
         next_r.istat[`RDLF_IRQ_NEAR] = 1'b1; // [RULE10]
      end
   end

   // Reset empties the FIFO and returns every register to zero.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rdata_o = r.rdata;
   assign irq_o = |(r.istat & r.imask);

   // Checks on the logic above; all but a_six_bit_packing_top hold for any legal register and link traffic, since shreg keeps bits after a mid-byte message end.
   a_empty_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE6]
      (r.cnt == '0) |-> !nxt_stat)
      else $error("status flag set on empty fifo");

   a_cnt_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE11]
      empty && in1 |=> !empty)
      else $error("empty stayed high after write");

   a_read_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE5]
      rd_i && addr_i == `RDLF_OFS_FLAGS |=> rdata_o[`RDLF_BIT_STAT] == $past(nxt_stat))
      else $error("flags read mismatch");

   a_six_bit_packing_top: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE3]
      in1 && r.active && rdlf_mode_e'(r.mode) == RDLF_SIX_BIT_PACKING |=> r.mem[$past(r.wp)][7:6] == 2'b00)
      else $error("six_bit_packing upper bits filled");

   a_near_level: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE10]
      near |-> (DEPTH_W - r.cnt) == {1'b0, r.thresh})
      else $error("near flag wrong");

   a_status_eom: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE8]
      msg_end_i && r.active && !bit_valid_i
      && (msg_eom_i == `RDLF_EOM_ERR || msg_eom_i == `RDLF_EOM_ABORT)
      |=> r.mem[$past(r.stat_slot)][5:0] == 6'h0)
      else $error("error or abort status with nonzero count");

   a_pop_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE9]
      rd_i && addr_i == `RDLF_OFS_PORT && !empty |=> r.rp == ptr_inc($past(r.rp)))
      else $error("fifo read did not advance");

   a_empty_port: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE11]
      rd_i && addr_i == `RDLF_OFS_PORT && empty |=> rdata_o == 8'h00)
      else $error("empty fifo read returned data");

   a_near_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE10]
      near && !r.near_q |=> r.istat[`RDLF_IRQ_NEAR])
      else $error("near interrupt not raised");

   a_msg_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE4]
      r.active && msg_end_i && !bit_valid_i |=> r.istat[`RDLF_IRQ_MSG])
      else $error("message interrupt not raised");

   a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE5]
      !rd_i |=> rdata_o == 8'h00)
      else $error("read data without read strobe");

   a_count_cap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE10]
      r.cnt <= DEPTH_W)
      else $error("occupancy above depth");

   a_flags_upper: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE5]
      rd_i && addr_i == `RDLF_OFS_FLAGS |=> rdata_o[7:5] == 3'b000)
      else $error("unused flag bits set");

   a_push_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE11]
      in1 && !rdf |=> r.cnt == $past(r.cnt) + 1'b1)
      else $error("occupancy did not grow on write");

   a_stat_slot: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE9]
      msg_start_i && !r.active && !full |=> r.is_stat[$past(r.wp)])
      else $error("status slot not marked");

   a_data_slot: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE9]
      in1 && r.active |=> !r.is_stat[$past(r.wp)])
      else $error("data byte marked as status");

   a_partial_close: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE9]
      r.active && bit_valid_i && r.nbits == width_m1 && (full || r.mcnt == `RDLF_CNT_MAX)
      |=> !r.active)
      else $error("message not closed at limit");

   a_pack_lsb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE1]
      r.active && bit_valid_i && r.nbits != width_m1
      |=> r.shreg[$past(r.nbits)] == $past(bit_i))
      else $error("bit not placed at its position");

   a_thresh_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE10]
      wr_i && addr_i == `RDLF_OFS_THRESH |=> r.thresh == $past(wdata_i[5:0]))
      else $error("threshold write lost");

   a_mode_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE3]
      wr_i && addr_i == `RDLF_OFS_CTRL |=> r.mode == $past(wdata_i[1:0]))
      else $error("mode write lost");

   a_imask_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE4]
      wr_i && addr_i == `RDLF_OFS_IMASK |=> r.imask == $past(wdata_i[2:0]))
      else $error("mask write lost");

   a_full_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE10]
      r.active && bit_valid_i && r.nbits == width_m1 && full |=> r.istat[`RDLF_IRQ_FULL])
      else $error("full interrupt not raised");
endmodule : rdlf_fifo_readout

/* testbench/rdlf_bit_source.sv */
`timescale 1ns/100ps
module rdlf_bit_source (
   input wire logic clk_sys_i, // System clock.
   input wire logic go_i, // Load a byte to send.
   input wire logic [7:0] byte_i, // Byte to send.
   input wire logic [3:0] nbits_i, // Bit count to send.
   output logic bit_valid_o, // Bit strobe.
   output logic bit_o, // Channel bit.
   output logic busy_o // Bits remain.
);
   logic [7:0] sh = 8'h00;
   logic [3:0] left = 4'h0;
   logic tog = 1'b0;
   // The idle line toggles so that a stale bit never passes for data.
   always_ff @(posedge clk_sys_i) begin
      tog <= ~tog;
      if (go_i) begin
         sh <= byte_i;
         left <= nbits_i;
      end else if (left != 4'h0) begin
         sh <= {1'b0, sh[7:1]};
         left <= left - 4'h1;
      end
   end
   assign busy_o = left != 4'h0;
   assign bit_valid_o = busy_o;
   assign bit_o = busy_o ? sh[0] : tog;
endmodule : rdlf_bit_source

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic msg_start_i = 1'b0;
   logic msg_end_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic go = 1'b0;
   logic [1:0] msg_eom_i = 2'h0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] tx_byte = 8'h00;
   logic [3:0] nbits = 4'h0;
   logic bit_valid_i, bit_i, busy, irq_o;
   logic [7:0] rdata_o;
   int failures = 0;
   int checked = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   rdlf_fifo_readout DUT (.clk_sys_i, .rst_n_i, .bit_valid_i, .bit_i, .msg_start_i,
      .msg_end_i, .msg_eom_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o);
   rdlf_bit_source src (.clk_sys_i, .go_i(go), .byte_i(tx_byte), .nbits_i(nbits),
      .bit_valid_o(bit_valid_i), .bit_o(bit_i), .busy_o(busy));
   task automatic tally_and_finish();
      if (failures == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      chk($sformatf("reg_%h", a), e, rdata_o);
   endtask : rd
   task automatic open_msg(input logic [7:0] b, input logic [3:0] n);
      @(posedge clk_sys_i);
      msg_start_i <= 1'b1;
      @(posedge clk_sys_i);
      msg_start_i <= 1'b0;
      go <= n != 4'h0;
      tx_byte <= b;
      nbits <= n;
      @(posedge clk_sys_i);
      go <= 1'b0;
      #1;
      for (int i = 0; i < 20 && busy; i++) begin
         @(posedge clk_sys_i);
         #1;
      end
      if (busy !== 1'b0) begin
         failures++;
         tally_and_finish();
      end
   endtask : open_msg
   task automatic close_msg(input logic [1:0] end_of_message_code);
      @(posedge clk_sys_i);
      msg_end_i <= 1'b1;
      msg_eom_i <= end_of_message_code;
      @(posedge clk_sys_i);
      msg_end_i <= 1'b0;
   endtask : close_msg
   initial begin
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(8'hb4, 8'h04);
      rd(8'hb3, 8'h00);
      rd(8'h55, 8'h00);
      wr(8'hc1, 8'h01);
      wr(8'hb1, 8'h01);
      open_msg(8'ha5, 4'h8);
      rd(8'hb4, 8'h18);
      close_msg(2'h0);
      rd(8'hb4, 8'h08);
      chk("irq_o", 8'h01, {7'h00, irq_o});
      rd(8'hb3, 8'h01);
      rd(8'hb4, 8'h00);
      rd(8'hb3, 8'ha5);
      rd(8'hb4, 8'h04);
      rd(8'hc0, 8'h01);
      wr(8'hc0, 8'h01);
      #1;
      chk("irq_o", 8'h00, {7'h00, irq_o});
      wr(8'hb1, 8'h02);
      open_msg(8'heb, 4'h6);
      close_msg(2'h0);
      rd(8'hb3, 8'h01);
      rd(8'hb3, 8'h2b);
      for (int e = 0; e < 4; e++) begin
         open_msg(8'h00, 4'h0);
         close_msg(e[1:0]);
         rd(8'hb3, {e[1:0], 6'h00});
      end
      rd(8'hb4, 8'h04);
      wr(8'hc0, 8'h07);
      wr(8'hb2, 8'h3f);
      rd(8'hb2, 8'h3f);
      rd(8'hb1, 8'h02);
      rd(8'hc1, 8'h01);
      open_msg(8'h00, 4'h0);
      rd(8'hb4, 8'h1a);
      rd(8'hc0, 8'h02);
      close_msg(2'h0);
      rd(8'hb3, 8'h00);
      rd(8'hb4, 8'h04);
      wr(8'hb2, 8'h00);
      wr(8'hb1, 8'h00);
      open_msg(8'h3c, 4'h8);
      close_msg(2'h0);
      rd(8'hb3, 8'h01);
      rd(8'hb3, 8'h3c);
      tally_and_finish();
   end
endmodule : testbench
